// ==== core/pms_top.sv ====
// power mode sequencer: power-up, four power states, done flag, port choice
// assumes supply_ok comes from the supply monitor and all inputs but the mode and select pins share core_clk
//
// What the document requires
// RQ1: host halts the internal processor by writing zero to run register first.
// RQ2: host clears hs_port_enable before leaving the normal power state.
// RQ3: host masks every interrupt source before leaving the normal state.
// RQ4: host clears all pending status flags before leaving the normal state.
// RQ5: normal to reduced starts mean absolute computation at once, readable now.
// RQ6: entering low power drives irq_line_a or irq_line_b low; host waits.
// RQ7: every transition into normal ends with irq_line_b low and transition_done set.
// RQ8: transition_done reads zero during the transition, one when finished.
// RQ9: host returning to normal waits for irq_line_b, then polls transition_done.
// RQ10: reduced from sleep or low pulls irq_line_b low when computation starts.
// RQ11: writing one to transition_done clears it and releases irq_line_b.
// RQ12: stay inactive a further 26 ms after supply first exceeds threshold.
// RQ13: mode_pin_b held low at power-up so the device starts in normal.
// RQ14: power-up until every function available takes about 40 ms.
// RQ15: host holds the reset pin high during the power-up procedure.
// RQ16: normal makes two-wire active; three select_pin falls switch to spi.
// RQ17: two_wire_lock set means select_pin toggles are ignored, no spi ever.
// RQ18: any port_lock_reg write while spi active locks spi permanently; the block takes the write only in normal or reduced.
// RQ19: locked spi is undone only by power removal or the reset pin.
// RQ20: a locked port choice persists across every power state change.
// RQ21: entry into normal after power-up loads defaults; processor starts idle.
// RQ22: supply below monitor threshold means inactive, no measurement at all.
// RQ23: low power period end: irq_line_a if all counters low, else irq_line_b.
// RQ24: sleep keeps two-wire, spi and fast capture ports non-functional.
// RQ25: mode and select pins are synchronised before any decision.
`timescale 1ns/1ps
`include "pms_regs.svh"
module pms_top
  import pms_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `PMS_HOLD_MS * `PMS_CLK_KHZ,
  parameter int unsigned BOOT_CYC = (`PMS_POWERUP_MS - `PMS_HOLD_MS) * `PMS_CLK_KHZ,
  parameter int unsigned WAKE_CYC = `PMS_WAKE_MS * `PMS_CLK_KHZ,
  parameter int unsigned LINE_CYC = `PMS_LINE_MS * `PMS_CLK_KHZ,
  parameter int PHASES = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // supply monitor
  input wire logic supply_ok,
  // pins from the host
  input wire logic mode_pin_a,
  input wire logic mode_pin_b,
  input wire logic select_pin,
  // register side strobes
  input wire logic stat1_wr,
  input wire logic [15:0] stat1_wdata,
  input wire logic lock_wr,
  input wire logic [7:0] lock_wdata,
  input wire logic dsp_start,
  // low power detector
  input wire logic [4:0] lp_period_count,
  input wire logic [PHASES-1:0] lp_phase_hit,
  // interrupt pins, active low
  output logic irq_line_a_n,
  output logic irq_line_b_n,
  // status
  output logic transition_done,
  output logic [3:0] power_state,
  output logic active,
  output logic mav_run,
  output logic defaults_load,
  output logic dsp_idle,
  output logic serial_port_en,
  output logic fast_capture_en,
  output logic spi_active,
  output logic two_wire_lock,
  output logic spi_lock
);

  localparam int unsigned SEL_A = 0;
  localparam int unsigned SEL_B = 1;
  localparam int unsigned SEL_S = 2;

  pms_state_t state_q, state_d;
  logic [19:0] timer_q, timer_d;
  logic [18:0] line_q;
  logic [4:0] lines_q;
  logic [5:0] hits_q [PHASES];
  logic [PHASES-1:0] over;
  logic done_q, mav_irq_q, lp_quiet_q, lp_busy_q;
  logic sel_prev_q;
  logic [1:0] falls_q;
  logic spi_q, tw_lock_q, spi_lock_q, dsp_idle_q;
  logic irq_a_n_q, irq_b_n_q, ser_en_q, hs_en_q, act_q, mav_q, dflt_q;
  pms_pstate_t ps_q;

  // synchronised pins
  pms_sync_if #(.W(3)) pin_if ();
  assign pin_if.raw = {select_pin, mode_pin_b, mode_pin_a};
  pms_sync #(.W(3)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pins(pin_if)
  );

  // mode request decode from synchronised pins [RQ25]
  wire [1:0] mode_s = {pin_if.sync[SEL_B], pin_if.sync[SEL_A]};
  wire sel_s = pin_if.sync[SEL_S];
  wire req_norm = (mode_s == `PMS_MODE_NORMAL);
  wire req_red = (mode_s == `PMS_MODE_REDUCED);
  wire req_low = (mode_s == `PMS_MODE_LOW);
  wire req_sleep = (mode_s == `PMS_MODE_SLEEP);
  wire tmr_zero = (timer_q == 20'h00000);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    timer_d = tmr_zero ? timer_q : timer_q - 20'h00001;
    unique case (state_q)
      PMS_ST_OFF: begin
        if (supply_ok) begin
          state_d = PMS_ST_HOLD; // [RQ12]
          timer_d = 20'(HOLD_CYC - 1);
        end
      end
      PMS_ST_HOLD: begin
        if (tmr_zero) begin
          state_d = PMS_ST_BOOT; // [RQ14]
          timer_d = 20'(BOOT_CYC - 1);
        end
      end
      PMS_ST_BOOT: begin
        if (tmr_zero) state_d = PMS_ST_NORMAL; // [RQ13]
      end
      PMS_ST_NORMAL: begin
        if (req_red) state_d = PMS_ST_REDUCED; // [RQ5]
        else if (req_low) state_d = PMS_ST_LOW;
        else if (req_sleep) state_d = PMS_ST_SLEEP;
      end
      PMS_ST_REDUCED, PMS_ST_LOW, PMS_ST_SLEEP: begin
        if (req_norm) begin
          state_d = PMS_ST_WAKE;
          timer_d = 20'(WAKE_CYC - 1);
        end else if (req_red && state_q != PMS_ST_REDUCED) begin
          state_d = PMS_ST_MAVW; // [RQ10]
          timer_d = 20'(WAKE_CYC - 1);
        end else if (req_low) begin
          state_d = PMS_ST_LOW;
        end else if (req_sleep) begin
          state_d = PMS_ST_SLEEP;
        end
      end
      PMS_ST_MAVW: begin
        if (tmr_zero) state_d = PMS_ST_REDUCED;
      end
      PMS_ST_WAKE: begin
        if (tmr_zero) state_d = PMS_ST_NORMAL;
      end
      default: state_d = PMS_ST_OFF;
    endcase
    if (!supply_ok) state_d = PMS_ST_OFF; // [RQ22]
  end

  // transition events
  wire in_norm = (state_q == PMS_ST_NORMAL);
  wire in_low = (state_q == PMS_ST_LOW);
  wire enter_norm = (state_d == PMS_ST_NORMAL) && !in_norm;
  wire from_boot = (state_q == PMS_ST_BOOT) && enter_norm;
  wire start_xfer = (state_d == PMS_ST_BOOT || state_d == PMS_ST_WAKE) &&
                    (state_d != state_q);
  wire done_clr = stat1_wr && stat1_wdata[`PMS_DONE_BIT];
  wire mav_start = (state_q == PMS_ST_MAVW) && (state_d == PMS_ST_REDUCED);
  wire off_d = (state_d == PMS_ST_OFF);

  // transition_done: set wins over a host clear [RQ7] [RQ8] [RQ11]
  wire done_d = enter_norm ? 1'h1 : ((done_clr || start_xfer || off_d) ? 1'h0 : done_q);
  // computation start flag on irq_line_b, held while in reduced [RQ10]
  wire mav_irq_d = mav_start ? 1'h1 :
                   (state_d == PMS_ST_REDUCED ? mav_irq_q : 1'h0);

  // low power measurement period: lines of 20 ms, lp_period_count + 1 of them
  wire line_end = (line_q == 19'(LINE_CYC - 1));
  wire period_end = in_low && line_end && (lines_q == lp_period_count);
  wire [5:0] limit = {1'h0, lp_period_count} + 6'h01;
  wire any_over = |over;

  // per phase counters of threshold crossings
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    assign over[p] = (hits_q[p] >= limit);
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) hits_q[p] <= 6'h00;
      else if (!in_low || period_end) hits_q[p] <= 6'h00;
      else if (lp_phase_hit[p] && hits_q[p] != 6'h3F) hits_q[p] <= hits_q[p] + 6'h01;
    end
  end

  // period result flags, renewed at each period end, cleared when the low power state is left [RQ6] [RQ23]
  wire keep_low = (state_d == PMS_ST_LOW);
  wire lp_quiet_d = !keep_low ? 1'h0 : (period_end ? !any_over : lp_quiet_q);
  wire lp_busy_d = !keep_low ? 1'h0 : (period_end ? any_over : lp_busy_q);

  // port selection [RQ16] [RQ17] [RQ18] [RQ19] [RQ20]
  wire sel_fall = sel_prev_q && !sel_s;
  wire can_toggle = in_norm && !tw_lock_q && !spi_q;
  wire to_spi = can_toggle && sel_fall && (falls_q == `PMS_SEL_FALLS - 2'h1);
  wire lock_ok = lock_wr && (in_norm || state_q == PMS_ST_REDUCED);
  wire tw_lock_d = off_d ? 1'h0 :
                   (tw_lock_q || (lock_ok && !spi_q && lock_wdata[`PMS_LOCK_BIT]));
  wire spi_lock_d = off_d ? 1'h0 : (spi_lock_q || (lock_ok && spi_q));
  wire spi_d = off_d ? 1'h0 : (spi_q || to_spi);

  // pin and port enables from the next state [RQ24]
  wire ser_en_d = (state_d == PMS_ST_NORMAL) || (state_d == PMS_ST_REDUCED);
  wire hs_en_d = (state_d == PMS_ST_NORMAL);
  wire act_d = !off_d && (state_d != PMS_ST_HOLD);
  pms_pstate_t ps_d;
  assign ps_d = (state_d == PMS_ST_NORMAL) ? PMS_PS_NORMAL :
                (state_d == PMS_ST_REDUCED) ? PMS_PS_REDUCED :
                (state_d == PMS_ST_LOW) ? PMS_PS_LOW :
                (state_d == PMS_ST_SLEEP) ? PMS_PS_SLEEP : PMS_PS_NONE;

  // sequencer and timers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PMS_ST_OFF;
      timer_q <= 20'h00000;
      line_q <= 19'h00000;
      lines_q <= 5'h00;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      line_q <= (!in_low || line_end) ? 19'h00000 : line_q + 19'h00001;
      lines_q <= (!in_low || period_end) ? 5'h00 : (line_end ? lines_q + 5'h01 : lines_q);
    end
  end

  // flags and port choice
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'h0;
      mav_irq_q <= 1'h0;
      lp_quiet_q <= 1'h0;
      lp_busy_q <= 1'h0;
      sel_prev_q <= 1'h1;
      falls_q <= 2'h0;
      spi_q <= 1'h0;
      tw_lock_q <= 1'h0;
      spi_lock_q <= 1'h0;
    end else begin
      done_q <= done_d;
      mav_irq_q <= mav_irq_d;
      lp_quiet_q <= lp_quiet_d;
      lp_busy_q <= lp_busy_d;
      sel_prev_q <= sel_s;
      falls_q <= (off_d || spi_d) ? 2'h0 : (can_toggle && sel_fall ? falls_q + 2'h1 : falls_q);
      spi_q <= spi_d;
      tw_lock_q <= tw_lock_d;
      spi_lock_q <= spi_lock_d;
    end
  end

  // registered outputs; processor idle from the first entry into normal [RQ21]
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_a_n_q <= `PMS_RST_IRQ_N;
      irq_b_n_q <= `PMS_RST_IRQ_N;
      ser_en_q <= 1'h0;
      hs_en_q <= 1'h0;
      act_q <= 1'h0;
      mav_q <= 1'h0;
      dflt_q <= 1'h0;
      dsp_idle_q <= `PMS_RST_DSP_IDLE;
      ps_q <= PMS_PS_NONE;
    end else begin
      irq_a_n_q <= !lp_quiet_d;
      irq_b_n_q <= !(done_d || mav_irq_d || lp_busy_d);
      ser_en_q <= ser_en_d;
      hs_en_q <= hs_en_d;
      act_q <= act_d;
      mav_q <= (state_d == PMS_ST_REDUCED);
      dflt_q <= from_boot;
      dsp_idle_q <= (from_boot || off_d) ? 1'h1 : ((in_norm && dsp_start) ? 1'h0 : dsp_idle_q);
      ps_q <= ps_d;
    end
  end

  assign irq_line_a_n = irq_a_n_q;
  assign irq_line_b_n = irq_b_n_q;
  assign transition_done = done_q;
  assign power_state = ps_q;
  assign active = act_q;
  assign mav_run = mav_q;
  assign defaults_load = dflt_q;
  assign dsp_idle = dsp_idle_q;
  assign serial_port_en = ser_en_q;
  assign fast_capture_en = hs_en_q;
  assign spi_active = spi_q;
  assign two_wire_lock = tw_lock_q;
  assign spi_lock = spi_lock_q;

  // checks
  property p_done_irq;
    @(posedge core_clk) disable iff (!rst_n) $rose(done_q) |-> !irq_b_n_q && ps_q == PMS_PS_NORMAL;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done set without irq or normal"); // [RQ7]
  property p_done_zero;
    @(posedge core_clk) disable iff (!rst_n)
      (state_q == PMS_ST_WAKE || state_q == PMS_ST_BOOT || state_q == PMS_ST_HOLD) |-> !done_q;
  endproperty
  a_done_zero: assert property (p_done_zero) else $error("done high in transition"); // [RQ8]
  property p_done_clr;
    @(posedge core_clk) disable iff (!rst_n)
      done_q && done_clr && !enter_norm |=> !done_q;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared"); // [RQ11]
  property p_hold;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(state_q == PMS_ST_HOLD) |-> !act_q throughout (##1 !act_q [*8]);
  endproperty
  a_hold: assert property (p_hold) else $error("active during hold-off"); // [RQ12]
  property p_supply;
    @(posedge core_clk) disable iff (!rst_n) !supply_ok |=> state_q == PMS_ST_OFF ##1 !act_q;
  endproperty
  a_supply: assert property (p_supply) else $error("not inactive after supply loss"); // [RQ22]
  property p_tw_lock;
    @(posedge core_clk) disable iff (!rst_n) tw_lock_q && !spi_q |=> !spi_q;
  endproperty
  a_tw_lock: assert property (p_tw_lock) else $error("spi taken despite lock"); // [RQ17]
  property p_spi_lock;
    @(posedge core_clk) disable iff (!rst_n) spi_lock_q && supply_ok |=> spi_q && spi_lock_q;
  endproperty
  a_spi_lock: assert property (p_spi_lock) else $error("spi lock lost"); // [RQ18]
  property p_sleep;
    @(posedge core_clk) disable iff (!rst_n)
      ps_q == PMS_PS_SLEEP |-> !ser_en_q && !hs_en_q;
  endproperty
  a_sleep: assert property (p_sleep) else $error("ports alive in sleep"); // [RQ24]
  property p_mav_now;
    @(posedge core_clk) disable iff (!rst_n)
      in_norm && state_d == PMS_ST_REDUCED |=> mav_q && irq_b_n_q == $past(irq_b_n_q);
  endproperty
  a_mav_now: assert property (p_mav_now) else $error("mean computation delayed"); // [RQ5]
  property p_lp_result;
    @(posedge core_clk) disable iff (!rst_n)
      period_end && keep_low |=> (irq_a_n_q != irq_b_n_q) || !done_q && !irq_b_n_q;
  endproperty
  a_lp_result: assert property (p_lp_result) else $error("no low power result"); // [RQ23]
  c_spi: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(spi_q));
  c_lp: cover property (@(posedge core_clk) disable iff (!rst_n) period_end);
  c_mav: cover property (@(posedge core_clk) disable iff (!rst_n) mav_start);
  c_wake: cover property (@(posedge core_clk) disable iff (!rst_n) enter_norm && !from_boot);

endmodule

// ==== include/pms_regs.svh ====
// constants of the power mode sequencer: bit positions, reset values, times
// assumes the clock rate constant matches the core_clk that drives the block
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

// core clock rate in kHz (25 MHz)
`define PMS_CLK_KHZ 25000
// hold-off after the supply monitor trips, in ms
`define PMS_HOLD_MS 26
// whole power-up time until every function is available, in ms
`define PMS_POWERUP_MS 40
// line period of the low power measurement, in ms (1/50 s)
`define PMS_LINE_MS 20
// wake time for a return to normal or a start of mean absolute computation, in ms
`define PMS_WAKE_MS 1

// transition_done position in irq_status_1
`define PMS_DONE_BIT 15
// two_wire_lock position in port_lock_reg
`define PMS_LOCK_BIT 1
// falling edges of select_pin that switch the port to spi
`define PMS_SEL_FALLS 2'h3

// mode pin codes {mode_pin_b, mode_pin_a}
`define PMS_MODE_NORMAL 2'h1
`define PMS_MODE_REDUCED 2'h0
`define PMS_MODE_LOW 2'h2
`define PMS_MODE_SLEEP 2'h3

// reset values
`define PMS_RST_DSP_IDLE 1'h1
`define PMS_RST_IRQ_N 1'h1

`endif

// ==== include/pms_pkg.sv ====
// types of the power mode sequencer
// assumes pms_regs.svh sits in the include path
package pms_pkg;

  // sequencer states, one-hot
  typedef enum logic [8:0] {
    PMS_ST_OFF     = 9'h001,
    PMS_ST_HOLD    = 9'h002,
    PMS_ST_BOOT    = 9'h004,
    PMS_ST_NORMAL  = 9'h008,
    PMS_ST_REDUCED = 9'h010,
    PMS_ST_LOW     = 9'h020,
    PMS_ST_SLEEP   = 9'h040,
    PMS_ST_MAVW    = 9'h080,
    PMS_ST_WAKE    = 9'h100
  } pms_state_t;

  // documented power state as shown at the status port, one-hot, all zero outside the four states
  typedef enum logic [3:0] {
    PMS_PS_NONE    = 4'h0,
    PMS_PS_NORMAL  = 4'h1,
    PMS_PS_REDUCED = 4'h2,
    PMS_PS_LOW     = 4'h4,
    PMS_PS_SLEEP   = 4'h8
  } pms_pstate_t;

endpackage

// ==== include/pms_sync_if.sv ====
// carrier between the sequencer and its pin synchroniser
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface pms_sync_if #(
  parameter int W = 3
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport sync_end (input raw, output sync);
  modport user_end (output raw, input sync);
endinterface

// ==== core/pms_sync.sv ====
// two flip-flop synchroniser for the mode and select pins
// assumes asynchronous pin levels and a free running core clock
`timescale 1ns/1ps
module pms_sync
  import pms_pkg::*;
#(
  parameter int W = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins in, synchronised levels out
  pms_sync_if.sync_end pins
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // per bit: first stage feeds only the second stage [RQ25]
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_q[i] <= 1'h1;
        sync_q[i] <= 1'h1;
      end else begin
        meta_q[i] <= pins.raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign pins.sync = sync_q;

endmodule

// ==== tb/pms_host_model.sv ====
// host model: mode pins, select pin and register strobes of the host side
// assumes the device samples all of them on rising edges of core_clk
`timescale 1ns/1ps
module pms_host_model (
  // clock and device answers
  input wire logic core_clk,
  input wire logic irq_line_b_n,
  input wire logic transition_done,
  // pins and strobes
  output logic mode_pin_a,
  output logic mode_pin_b,
  output logic select_pin,
  output logic stat1_wr,
  output logic [15:0] stat1_wdata,
  output logic lock_wr,
  output logic [7:0] lock_wdata,
  output logic dsp_start
);
  int dsp_run = 0;
  // mode_pin_b low before power, mode_pin_a left high, strobes idle
  initial begin
    mode_pin_a = 1'b1;
    mode_pin_b = 1'b0;
    select_pin = 1'b1;
    stat1_wr = 1'b0;
    stat1_wdata = 16'h0000;
    lock_wr = 1'b0;
    lock_wdata = 8'h00;
    dsp_start = 1'b0;
  end
  // one cycle write, data then released to its inverse
  task automatic wr_stat1(input logic [15:0] d);
    @(posedge core_clk);
    stat1_wr <= 1'b1;
    stat1_wdata <= d;
    @(posedge core_clk);
    stat1_wr <= 1'b0;
    stat1_wdata <= ~d;
  endtask
  task automatic wr_lock(input logic [7:0] d);
    @(posedge core_clk);
    lock_wr <= 1'b1;
    lock_wdata <= d;
    @(posedge core_clk);
    lock_wr <= 1'b0;
    lock_wdata <= ~d;
  endtask
  task automatic run_dsp();
    @(posedge core_clk);
    dsp_start <= 1'b1;
    dsp_run = 1;
    @(posedge core_clk);
    dsp_start <= 1'b0;
  endtask
  // leaving normal: dsp_run cleared and all status flags cleared by writing 16'hFFFF to stat1
  task automatic set_mode(input logic b, input logic a);
    if ({mode_pin_b, mode_pin_a} == 2'h1 && {b, a} != 2'h1) begin
      dsp_run = 0;
      wr_stat1(16'hFFFF);
    end
    @(posedge core_clk);
    mode_pin_b <= b;
    mode_pin_a <= a;
  endtask
  // one high to low toggle of select_pin, g cycles low and g high
  task automatic fall_sel(input int g);
    @(posedge core_clk);
    select_pin <= 1'b0;
    repeat (g) @(posedge core_clk);
    select_pin <= 1'b1;
    repeat (g) @(posedge core_clk);
  endtask
  // return to normal: wait for irq_line_b, then poll transition_done
  task automatic poll_done();
    for (int n = 0; n < 100 && irq_line_b_n !== 1'b0; n++) @(negedge core_clk);
    for (int n = 0; n < 100 && transition_done !== 1'b1; n++) @(negedge core_clk);
  endtask
endmodule

// ==== tb/test_power_mode_sequencer.sv ====
// bench of the power mode sequencer with a host model and a bench model
// assumes shortened hold, boot, wake and line counts
`timescale 1ns/1ps
module test_power_mode_sequencer;
  import pms_pkg::*;
  localparam int HC = 20;
  localparam int BC = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic [4:0] lp_period_count = 5'h00;
  logic [2:0] lp_phase_hit = 3'h0;
  logic mode_pin_a, mode_pin_b, select_pin, stat1_wr, lock_wr, dsp_start;
  logic [15:0] stat1_wdata;
  logic [7:0] lock_wdata;
  logic irq_line_a_n, irq_line_b_n, transition_done, active, mav_run;
  logic defaults_load, dsp_idle, serial_port_en, fast_capture_en;
  logic spi_active, two_wire_lock, spi_lock;
  logic [3:0] power_state;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  int m_spi, m_tw, m_sl, m_falls, r;
  logic bad;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  pms_top #(.HOLD_CYC(HC), .BOOT_CYC(BC), .WAKE_CYC(5), .LINE_CYC(10), .PHASES(3)) u_pms_top (
    .core_clk(core_clk), .rst_n(rst_n), .supply_ok(supply_ok),
    .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .select_pin(select_pin),
    .stat1_wr(stat1_wr), .stat1_wdata(stat1_wdata), .lock_wr(lock_wr),
    .lock_wdata(lock_wdata), .dsp_start(dsp_start), .lp_period_count(lp_period_count),
    .lp_phase_hit(lp_phase_hit), .irq_line_a_n(irq_line_a_n), .irq_line_b_n(irq_line_b_n),
    .transition_done(transition_done), .power_state(power_state), .active(active),
    .mav_run(mav_run), .defaults_load(defaults_load), .dsp_idle(dsp_idle),
    .serial_port_en(serial_port_en), .fast_capture_en(fast_capture_en),
    .spi_active(spi_active), .two_wire_lock(two_wire_lock), .spi_lock(spi_lock));
  pms_host_model u_pms_host_model (
    .core_clk(core_clk), .irq_line_b_n(irq_line_b_n), .transition_done(transition_done),
    .mode_pin_a(mode_pin_a), .mode_pin_b(mode_pin_b), .select_pin(select_pin),
    .stat1_wr(stat1_wr), .stat1_wdata(stat1_wdata), .lock_wr(lock_wr),
    .lock_wdata(lock_wdata), .dsp_start(dsp_start));
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_ps(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t power state got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_ps(input logic [3:0] ps);
    for (int n = 0; n < 60 && power_state !== ps; n++) @(negedge core_clk);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 200 && irq_line_a_n === 1'b1 && irq_line_b_n === 1'b1; n++)
      @(negedge core_clk);
  endtask
  task automatic hits(input int k, input logic [2:0] m);
    repeat (k) begin
      @(posedge core_clk);
      lp_phase_hit <= m;
      @(posedge core_clk);
      lp_phase_hit <= 3'h0;
    end
  endtask
  // power removal and return; cycle counts from supply_ok rising
  task automatic powerup();
    int n;
    int na;
    logic dl;
    na = -1;
    dl = 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b0;
    supply_ok <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    supply_ok <= 1'b1;
    m_spi = 0;
    m_tw = 0;
    m_sl = 0;
    m_falls = 0;
    for (n = 0; n < 200 && transition_done !== 1'b1; n++) begin
      @(negedge core_clk);
      if (na < 0 && active === 1'b1) na = n;
      dl = dl | (defaults_load === 1'b1);
    end
    chk_bit(na >= HC && na <= HC + 3, 1'b1);
    chk_bit(n >= HC + BC && n <= HC + BC + 4, 1'b1);
    chk_bit(irq_line_b_n, 1'b0);
    chk_ps(power_state, PMS_PS_NORMAL);
    chk_bit(dsp_idle, 1'b1);
    chk_bit(serial_port_en & fast_capture_en, 1'b1);
    @(negedge core_clk);
    chk_bit(dl | (defaults_load === 1'b1), 1'b1);
    chk_bit(spi_active, 1'b0);
    chk_bit(spi_lock, 1'b0);
    chk_bit(two_wire_lock, 1'b0);
  endtask
  task automatic falls(input int k);
    for (int i = 0; i < k; i++) begin
      u_pms_host_model.fall_sel(1 + $urandom % 3);
      if (m_spi == 0 && m_tw == 0) m_falls++;
      if (m_falls == 3) m_spi = 1;
      repeat (4) @(negedge core_clk);
      chk_bit(spi_active, m_spi[0]);
    end
  endtask
  // main sequence
  initial begin
    r = $urandom(32'h16d52183);
    powerup();
    r = $urandom;
    u_pms_host_model.wr_stat1(r[15:0] & 16'h7FFF);
    repeat (2) @(negedge core_clk);
    chk_bit(transition_done, 1'b1);
    u_pms_host_model.wr_stat1(r[15:0] | 16'h8000);
    repeat (2) @(negedge core_clk);
    chk_bit(transition_done, 1'b0);
    chk_bit(irq_line_b_n, 1'b1);
    u_pms_host_model.run_dsp();
    repeat (2) @(negedge core_clk);
    chk_bit(dsp_idle, 1'b0);
    falls(3);
    u_pms_host_model.wr_lock(r[23:16] & 8'hFD);
    m_sl = m_spi;
    repeat (2) @(negedge core_clk);
    chk_bit(spi_lock, m_sl[0]);
    // normal to reduced, then low with too few hits
    u_pms_host_model.set_mode(1'b0, 1'b0);
    wait_ps(PMS_PS_REDUCED);
    chk_bit(mav_run, 1'b1);
    chk_bit(irq_line_b_n, 1'b1);
    r = $urandom % 4;
    @(posedge core_clk);
    lp_period_count <= r[4:0];
    u_pms_host_model.set_mode(1'b1, 1'b0);
    wait_ps(PMS_PS_LOW);
    hits(r, 3'h7);
    wait_irq();
    chk_bit(irq_line_a_n, 1'b0);
    chk_bit(irq_line_b_n, 1'b1);
    u_pms_host_model.set_mode(1'b1, 1'b1);
    wait_ps(PMS_PS_SLEEP);
    chk_bit(serial_port_en | fast_capture_en, 1'b0);
    chk_bit(spi_active & spi_lock, 1'b1);
    // sleep to reduced, then back to normal
    u_pms_host_model.set_mode(1'b0, 1'b0);
    for (int n = 0; n < 60 && irq_line_b_n !== 1'b0; n++) @(negedge core_clk);
    @(negedge core_clk);
    chk_bit(mav_run & ~irq_line_b_n, 1'b1);
    u_pms_host_model.set_mode(1'b0, 1'b1);
    wait_ps(PMS_PS_NONE);
    @(negedge core_clk);
    bad = 1'b0;
    for (int n = 0; n < 60 && irq_line_b_n !== 1'b0; n++) begin
      bad = bad | (transition_done !== 1'b0);
      @(negedge core_clk);
    end
    chk_bit(bad, 1'b0);
    u_pms_host_model.poll_done();
    chk_bit(transition_done & ~irq_line_b_n, 1'b1);
    chk_bit(spi_active & spi_lock, 1'b1);
    u_pms_host_model.wr_stat1(16'h8000);
    // reset undoes spi, then two-wire lock holds against toggles
    powerup();
    u_pms_host_model.wr_lock(8'($urandom) | 8'h02);
    m_tw = 1;
    repeat (2) @(negedge core_clk);
    chk_bit(two_wire_lock, 1'b1);
    falls(3);
    r = $urandom % 4;
    @(posedge core_clk);
    lp_period_count <= r[4:0];
    u_pms_host_model.set_mode(1'b1, 1'b0);
    wait_ps(PMS_PS_LOW);
    hits(r + 1, 3'h1 << ($urandom % 3));
    wait_irq();
    chk_bit(irq_line_b_n, 1'b0);
    chk_bit(irq_line_a_n, 1'b1);
    chk_bit(two_wire_lock, 1'b1);
    // low to reduced: start of mean absolute computation shown on irq_line_b
    u_pms_host_model.set_mode(1'b0, 1'b0);
    wait_ps(PMS_PS_REDUCED);
    chk_bit(mav_run & ~irq_line_b_n, 1'b1);
    chk_bit(two_wire_lock, 1'b1);
    @(posedge core_clk);
    supply_ok <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk_bit(active, 1'b0);
    chk_ps(power_state, PMS_PS_NONE);
    end_of_test();
  end
endmodule
